// ---- rtl/cpb_regs.svh ----
// constants for the clock, power and boot configuration block
// assumes inclusion by the design modules cpb_wait_ctr and cpb_top
`ifndef CPB_REGS_SVH
`define CPB_REGS_SVH
// --------------------------------------------------------------
// boot_config_zero field positions
// --------------------------------------------------------------
`define CPB_PD_BIT 0
`define CPB_BW_BIT 1
`define CPB_WCTL_BIT 2
`define CPB_SPLIT_BUS_SEL_BIT 3
`define CPB_WS_LSB 4
`define CPB_WS_MSB 5
`define CPB_FIXED_LSB 6
`define CPB_FIXED_MSB 7
`define CPB_CFG0_RST 8'hC0
`define CPB_BYTE1_RST 8'h00
// --------------------------------------------------------------
// sleep keys, wait step, strap patterns
// --------------------------------------------------------------
`define CPB_KEY_IDLE 8'h01
`define CPB_KEY_PDOWN 8'h02
`define CPB_KEY_STBY 8'h03
`define CPB_WS_STEP 4'h5
`define CPB_STRAP_X1 2'h0
`define CPB_STRAP_X2 2'h1
`define CPB_STRAP_X4 2'h3
`define CPB_DIV_LAST 2'h3
// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define CPB_CORE_PERIOD_NS 10
`define CPB_F_MAX_MHZ 50
`endif

// ---- rtl/cpb_pkg.sv ----
// types for the clock, power and boot configuration block
// assumes cpb_regs.svh is on the include path
package cpb_pkg;
   // power mode
   typedef enum logic [1:0] {
      CPB_PM_RUN = 2'b00,
      CPB_PM_IDLE = 2'b01,
      CPB_PM_STBY = 2'b10,
      CPB_PM_PDOWN = 2'b11
   } cpb_pm_t;
   // boot sequence
   typedef enum logic [1:0] {
      CPB_BOOT_LOAD0 = 2'b00,
      CPB_BOOT_FETCH1 = 2'b01,
      CPB_BOOT_DONE = 2'b10
   } cpb_boot_t;
endpackage : cpb_pkg

// ---- rtl/cpb_wait_if.sv ----
// carrier between the boot sequencer and its wait-state counter
// assumes one clock domain shared by both ends
`timescale 1ns/10ps
interface cpb_wait_if;
   logic start;
   logic tick;
   logic ready;
   logic [3:0] count;
   logic done;
   modport seq (output start, output tick, output ready, output count, input done);
   modport ctr (input start, input tick, input ready, input count, output done);
endinterface : cpb_wait_if

// ---- rtl/cpb_wait_ctr.sv ----
// wait-state counter for the external fetch of boot byte one
// assumes tick marks the end of each state time
`timescale 1ns/10ps
`include "cpb_regs.svh"
module cpb_wait_ctr
   import cpb_pkg::*;
#(
   parameter int WAIT_W = 4
) (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   cpb_wait_if.ctr wif
);
   // ----------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------
   if (WAIT_W != 4) begin : g_bad_width
      $error("cpb_wait_ctr: WAIT_W must be 4");
   end

   logic [WAIT_W-1:0] count_reg;
   logic [WAIT_W-1:0] count_next;
   logic busy_reg;
   logic busy_next;
   logic zero_reg;
   logic zero_next;
   logic done_reg;
   logic done_next;

   // ----------------------------------------------------------
   // next state
   // ----------------------------------------------------------
   always_comb begin
      count_next = count_reg;
      busy_next = busy_reg;
      zero_next = zero_reg;
      done_next = 1'b0;
      if (wif.start) begin
         count_next = wif.count;
         busy_next = 1'b1;
         zero_next = (wif.count == 4'h0);
      end else if (busy_reg) begin
         if (count_reg != 4'h0) begin
            if (wif.tick) begin
               count_next = count_reg - 4'h1;
            end
         end else if (zero_reg || wif.ready) begin
            done_next = 1'b1;
            busy_next = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count_reg <= 4'h0;
         busy_reg <= 1'b0;
         zero_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         busy_reg <= busy_next;
         zero_reg <= zero_next;
         done_reg <= done_next;
      end
   end

   assign wif.done = done_reg;
endmodule : cpb_wait_ctr

// ---- rtl/cpb_top.sv ----
// clock multiplier, phase generation, power modes and boot configuration
// assumes straps, keys and interrupts are synchronous to core_clk_in,
// which stands for the fastest (times four) internal clock
`timescale 1ns/10ps
`include "cpb_regs.svh"
// Operation
// - straps 00, 01, 11 give times one, two, four operating rate
// - each phase clock runs at half rate; state time is two periods
// - valid key enters power saving when enabled; invalid key resets
// - idle stops processor clock, peripheral clocks keep running
// - idle left on hardware reset or any enabled interrupt
// - standby holds all internal clocks low, oscillator keeps running
// - standby left only on hardware reset or enabled external interrupt
// - powerdown holds clocks low and stops oscillator; state is kept
// - reset sequence copies boot bytes into configuration registers
// - config register zero gates deep sleep keys, selects write mode
// - wait field codes 00,01,10,11 give 0,5,10,15 wait states
// - nonzero wait count extends while ready is low
// - bit 0 enables powerdown and standby when one
// - bit 1 selects 8-bit or 16-bit fetch of boot byte one
// - bit 3 selects multiplexed or data-only shared bus for fetch
// - bit 2 selects split write strobes or high enable plus strobe
module cpb_top
   import cpb_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic mult_strap_low_in,
   input wire logic mult_strap_high_in,
   input wire logic [7:0] boot_byte_zero_in,
   input wire logic [7:0] boot_byte_one_in,
   input wire logic ready_in,
   input wire logic sleep_instr_in,
   input wire logic [7:0] sleep_key_in,
   input wire logic int_pending_in,
   input wire logic ext_int_pending_in,
   output logic phase_one_clk_out,
   output logic phase_two_clk_out,
   output logic state_clock_out,
   output logic cpu_clk_en_out,
   output logic periph_clk_en_out,
   output logic osc_run_out,
   output logic key_reset_out,
   output logic [7:0] boot_config_zero_out,
   output logic [7:0] boot_byte_one_out,
   output logic config_done_out,
   output logic fetch_req_out,
   output logic fetch_width_sel_out,
   output logic split_bus_sel_out,
   output logic write_ctl_sel_out,
   output cpb_pm_t pm_mode_out
);
   cpb_wait_if wif ();

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   cpb_boot_t boot_reg;
   cpb_boot_t boot_next;
   cpb_pm_t pm_reg;
   cpb_pm_t pm_next;
   logic [1:0] strap_reg;
   logic [1:0] strap_next;
   logic [1:0] div_reg;
   logic [1:0] div_next;
   logic phase_reg;
   logic phase_next;
   logic [7:0] cfg0_reg;
   logic [7:0] cfg0_next;
   logic [7:0] byte1_reg;
   logic [7:0] byte1_next;
   logic ph1_reg;
   logic ph1_next;
   logic ph2_reg;
   logic ph2_next;
   logic cpu_en_reg;
   logic cpu_en_next;
   logic per_en_reg;
   logic per_en_next;
   logic osc_reg;
   logic osc_next;
   logic key_rst_reg;
   logic key_rst_next;
   logic start_reg;
   logic start_next;
   logic done_reg;
   logic done_next;
   logic freq_reg;
   logic freq_next;
   logic ftick;
   logic clocks_on;
   logic clocks_on_next;

   // ----------------------------------------------------------
   // operating rate tick from the strap setting
   // ----------------------------------------------------------
   always_comb begin
      case (strap_reg)
         `CPB_STRAP_X4: ftick = 1'b1;
         `CPB_STRAP_X2: ftick = div_reg[0];
         default: ftick = (div_reg == `CPB_DIV_LAST);
      endcase
   end

   assign clocks_on = (pm_reg == CPB_PM_RUN) || (pm_reg == CPB_PM_IDLE);
   assign clocks_on_next = (pm_next == CPB_PM_RUN) || (pm_next == CPB_PM_IDLE);

   always_comb begin
      div_next = div_reg;
      phase_next = phase_reg;
      if (pm_reg != CPB_PM_PDOWN) begin
         div_next = div_reg + 2'h1;
      end
      if (ftick && clocks_on) begin
         phase_next = ~phase_reg;
      end
      ph1_next = clocks_on_next && !phase_next;
      ph2_next = clocks_on_next && phase_next;
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         div_reg <= 2'h0;
         phase_reg <= 1'b0;
         ph1_reg <= 1'b0;
         ph2_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         phase_reg <= phase_next;
         ph1_reg <= ph1_next;
         ph2_reg <= ph2_next;
      end
   end

   // ----------------------------------------------------------
   // wait counter hookup
   // ----------------------------------------------------------
   assign wif.start = start_reg;
   assign wif.tick = ftick && phase_reg;
   assign wif.ready = ready_in;
   assign wif.count = 4'(cfg0_reg[`CPB_WS_MSB:`CPB_WS_LSB] * `CPB_WS_STEP);

   cpb_wait_ctr #(
      .WAIT_W(4)
   ) u_wait (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .wif(wif)
   );

   // ----------------------------------------------------------
   // boot sequence and power modes
   // ----------------------------------------------------------
   always_comb begin
      boot_next = boot_reg;
      pm_next = pm_reg;
      strap_next = strap_reg;
      cfg0_next = cfg0_reg;
      byte1_next = byte1_reg;
      key_rst_next = 1'b0;
      start_next = 1'b0;
      case (boot_reg)
         CPB_BOOT_LOAD0: begin
            strap_next = {mult_strap_high_in, mult_strap_low_in};
            cfg0_next = boot_byte_zero_in;
            start_next = 1'b1;
            boot_next = CPB_BOOT_FETCH1;
         end
         CPB_BOOT_FETCH1: begin
            if (wif.done) begin
               byte1_next = boot_byte_one_in;
               boot_next = CPB_BOOT_DONE;
            end
         end
         CPB_BOOT_DONE: begin
            case (pm_reg)
               CPB_PM_RUN: begin
                  if (sleep_instr_in) begin
                     case (sleep_key_in)
                        `CPB_KEY_IDLE: pm_next = CPB_PM_IDLE;
                        `CPB_KEY_PDOWN: begin
                           if (cfg0_reg[`CPB_PD_BIT]) begin
                              pm_next = CPB_PM_PDOWN;
                           end
                        end
                        `CPB_KEY_STBY: begin
                           if (cfg0_reg[`CPB_PD_BIT]) begin
                              pm_next = CPB_PM_STBY;
                           end
                        end
                        default: begin
                           key_rst_next = 1'b1;
                           boot_next = CPB_BOOT_LOAD0;
                        end
                     endcase
                  end
               end
               CPB_PM_IDLE: begin
                  if (int_pending_in) begin
                     pm_next = CPB_PM_RUN;
                  end
               end
               CPB_PM_STBY: begin
                  if (ext_int_pending_in) begin
                     pm_next = CPB_PM_RUN;
                  end
               end
               default: pm_next = CPB_PM_PDOWN;
            endcase
         end
         default: boot_next = CPB_BOOT_LOAD0;
      endcase
      cpu_en_next = (pm_next == CPB_PM_RUN) && (boot_next == CPB_BOOT_DONE);
      per_en_next = (pm_next == CPB_PM_RUN) || (pm_next == CPB_PM_IDLE);
      osc_next = (pm_next != CPB_PM_PDOWN);
      done_next = (boot_next == CPB_BOOT_DONE);
      freq_next = (boot_next == CPB_BOOT_FETCH1);
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         boot_reg <= CPB_BOOT_LOAD0;
         pm_reg <= CPB_PM_RUN;
         strap_reg <= `CPB_STRAP_X1;
         cfg0_reg <= `CPB_CFG0_RST;
         byte1_reg <= `CPB_BYTE1_RST;
         key_rst_reg <= 1'b0;
         start_reg <= 1'b0;
         done_reg <= 1'b0;
         freq_reg <= 1'b0;
         cpu_en_reg <= 1'b0;
         per_en_reg <= 1'b0;
         osc_reg <= 1'b1;
      end else begin
         boot_reg <= boot_next;
         pm_reg <= pm_next;
         strap_reg <= strap_next;
         cfg0_reg <= cfg0_next;
         byte1_reg <= byte1_next;
         key_rst_reg <= key_rst_next;
         start_reg <= start_next;
         done_reg <= done_next;
         freq_reg <= freq_next;
         cpu_en_reg <= cpu_en_next;
         per_en_reg <= per_en_next;
         osc_reg <= osc_next;
      end
   end

   // ----------------------------------------------------------
   // outputs
   // ----------------------------------------------------------
   assign phase_one_clk_out = ph1_reg;
   assign phase_two_clk_out = ph2_reg;
   assign state_clock_out = ph1_reg;
   assign cpu_clk_en_out = cpu_en_reg;
   assign periph_clk_en_out = per_en_reg;
   assign osc_run_out = osc_reg;
   assign key_reset_out = key_rst_reg;
   assign boot_config_zero_out = cfg0_reg;
   assign boot_byte_one_out = byte1_reg;
   assign config_done_out = done_reg;
   assign fetch_req_out = freq_reg;
   assign fetch_width_sel_out = cfg0_reg[`CPB_BW_BIT];
   assign split_bus_sel_out = cfg0_reg[`CPB_SPLIT_BUS_SEL_BIT];
   assign write_ctl_sel_out = cfg0_reg[`CPB_WCTL_BIT];
   assign pm_mode_out = pm_reg;
endmodule : cpb_top

// ---- verif/cpb_top_props.sv ----
// assertions on the clock, power and boot block ports
// assumes bind into cpb_top, one clock domain
`timescale 1ns/10ps
module cpb_top_props
   import cpb_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic sleep_instr_in,
   input wire logic [7:0] sleep_key_in,
   input wire logic int_pending_in,
   input wire logic ext_int_pending_in,
   input wire logic phase_one_clk_out,
   input wire logic phase_two_clk_out,
   input wire logic cpu_clk_en_out,
   input wire logic periph_clk_en_out,
   input wire logic osc_run_out,
   input wire logic key_reset_out,
   input wire logic [7:0] boot_config_zero_out,
   input wire logic config_done_out,
   input wire logic fetch_req_out,
   input wire logic fetch_width_sel_out,
   input wire logic split_bus_sel_out,
   input wire logic write_ctl_sel_out,
   input wire cpb_pm_t pm_mode_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   logic take;
   assign take = sleep_instr_in && config_done_out && pm_mode_out == CPB_PM_RUN;
   a_frozen_clk_low: assert property (pm_mode_out inside {CPB_PM_STBY, CPB_PM_PDOWN}
      |-> !phase_one_clk_out && !phase_two_clk_out) else $error("clock not frozen low");
   a_osc_pdown_only: assert property (osc_run_out == (pm_mode_out != CPB_PM_PDOWN))
      else $error("oscillator state wrong");
   a_idle_clk_en: assert property (pm_mode_out == CPB_PM_IDLE
      |-> !cpu_clk_en_out && periph_clk_en_out) else $error("idle enables wrong");
   a_idle_wake_int: assert property (pm_mode_out == CPB_PM_IDLE && int_pending_in
      |=> pm_mode_out == CPB_PM_RUN && cpu_clk_en_out) else $error("idle not left");
   a_stby_hold: assert property (pm_mode_out == CPB_PM_STBY && !ext_int_pending_in
      |=> pm_mode_out == CPB_PM_STBY) else $error("standby left early");
   a_stby_wake_ext: assert property (pm_mode_out == CPB_PM_STBY && ext_int_pending_in
      |=> pm_mode_out == CPB_PM_RUN) else $error("standby not left");
   a_bad_key_reset: assert property (take && !(sleep_key_in inside {8'h01, 8'h02, 8'h03})
      |=> key_reset_out ##1 !key_reset_out) else $error("bad key not reset");
   a_idle_key_taken: assert property (take && sleep_key_in == 8'h01
      |=> pm_mode_out == CPB_PM_IDLE) else $error("idle not entered");
   a_deep_key_gate: assert property (take && sleep_key_in inside {8'h02, 8'h03}
      && !boot_config_zero_out[0] |=> pm_mode_out == CPB_PM_RUN && !key_reset_out)
      else $error("gated key honoured");
   a_cfg_field_sel: assert property ({split_bus_sel_out, write_ctl_sel_out, fetch_width_sel_out}
      == boot_config_zero_out[3:1]) else $error("select outputs wrong");
   a_fetch_end_done: assert property ($rose(config_done_out) |-> $fell(fetch_req_out))
      else $error("fetch not closed");
   a_phase_one_hot: assert property (config_done_out && pm_mode_out == CPB_PM_RUN
      |-> phase_one_clk_out != phase_two_clk_out) else $error("phases overlap or stopped");
endmodule : cpb_top_props
bind cpb_top cpb_top_props u_props (
   .core_clk_in(core_clk_in),
   .reset_n_in(reset_n_in),
   .sleep_instr_in(sleep_instr_in),
   .sleep_key_in(sleep_key_in),
   .int_pending_in(int_pending_in),
   .ext_int_pending_in(ext_int_pending_in),
   .phase_one_clk_out(phase_one_clk_out),
   .phase_two_clk_out(phase_two_clk_out),
   .cpu_clk_en_out(cpu_clk_en_out),
   .periph_clk_en_out(periph_clk_en_out),
   .osc_run_out(osc_run_out),
   .key_reset_out(key_reset_out),
   .boot_config_zero_out(boot_config_zero_out),
   .config_done_out(config_done_out),
   .fetch_req_out(fetch_req_out),
   .fetch_width_sel_out(fetch_width_sel_out),
   .split_bus_sel_out(split_bus_sel_out),
   .write_ctl_sel_out(write_ctl_sel_out),
   .pm_mode_out(pm_mode_out)
);

// ---- verif/cpb_fetch_mem.sv ----
// external memory answering the fetch of boot byte one
// assumes it sits on the core clock of the bench
`timescale 1ns/10ps
module cpb_fetch_mem (
   input wire logic core_clk_in,
   input wire logic fetch_req_in,
   input wire logic [7:0] data_in,
   input wire logic [7:0] stall_in,
   output logic ready_out,
   output logic [7:0] byte_out
);
   logic [7:0] cnt = 8'h00;
   logic idle_t = 1'b0;
   always @(posedge core_clk_in) begin
      cnt <= fetch_req_in ? cnt + 8'h01 : 8'h00;
      idle_t <= ~idle_t;
   end
   // ready high whole fetch unless a stall is asked for
   assign ready_out = fetch_req_in ? (cnt >= stall_in) : idle_t;
   assign byte_out = fetch_req_in ? data_in : ~data_in;
endmodule : cpb_fetch_mem

// ---- verif/testbench.sv ----
// self-checking bench for the clock, power and boot block
// assumes cpb_top, its checker and cpb_fetch_mem compiled first
`timescale 1ns/10ps
module testbench;
   import cpb_pkg::*;
   logic core_clk_in = 1'b0;
   logic reset_n_in;
   logic [1:0] strap = 2'h3;
   logic [7:0] cfg_in = 8'hC0;
   logic [7:0] data = 8'h00;
   logic [7:0] stall = 8'h00;
   logic sleep_instr = 1'b0;
   logic [7:0] key = 8'h00;
   logic int_p = 1'b0;
   logic ext_p = 1'b0;
   logic ph1, ph2, sclk, cpu_en, per_en, osc, krst, done, freq, bw, dmx, wctl, rdy;
   logic [7:0] cfg0, b1, b1_in;
   cpb_pm_t pm;
   logic [15:0] exp_q[$];
   logic [31:0] rnd = 32'h55;
   int error_cnt = 0;
   int checked = 0;
   int len;
   int k;
   always #5 core_clk_in = ~core_clk_in;
   cpb_top dut_u (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .mult_strap_low_in(strap[0]), .mult_strap_high_in(strap[1]),
      .boot_byte_zero_in(cfg_in), .boot_byte_one_in(b1_in), .ready_in(rdy),
      .sleep_instr_in(sleep_instr), .sleep_key_in(key), .int_pending_in(int_p),
      .ext_int_pending_in(ext_p), .phase_one_clk_out(ph1), .phase_two_clk_out(ph2),
      .state_clock_out(sclk), .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en),
      .osc_run_out(osc), .key_reset_out(krst), .boot_config_zero_out(cfg0),
      .boot_byte_one_out(b1), .config_done_out(done), .fetch_req_out(freq),
      .fetch_width_sel_out(bw), .split_bus_sel_out(dmx), .write_ctl_sel_out(wctl),
      .pm_mode_out(pm));
   cpb_fetch_mem mem_u (.core_clk_in(core_clk_in), .fetch_req_in(freq), .data_in(data),
      .stall_in(stall), .ready_out(rdy), .byte_out(b1_in));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   task automatic wait_boot(output int n_req);
      int n;
      n_req = 0;
      for (n = 0; n < 400 && done !== 1'b1; n++) begin
         @(posedge core_clk_in);
         #1;
         if (freq === 1'b1) n_req++;
      end
      if (done !== 1'b1) begin
         error_cnt++;
         stop_test();
      end
   endtask : wait_boot
   task automatic boot(input logic [1:0] s, input logic [7:0] c, input logic [7:0] st);
      rnd = xs(rnd);
      @(posedge core_clk_in);
      reset_n_in <= 1'b0;
      strap <= s;
      cfg_in <= c;
      data <= rnd[7:0];
      stall <= st;
      exp_q.push_back({c, rnd[7:0]});
      repeat (3) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      wait_boot(len);
   endtask : boot
   task automatic count_ph(output logic [15:0] t, output logic [15:0] u);
      int n;
      logic last;
      logic last_s;
      t = 16'h0;
      u = 16'h0;
      last = ph1;
      last_s = sclk;
      for (n = 0; n < 32; n++) begin
         @(posedge core_clk_in);
         #1;
         if (ph1 !== last) t++;
         if (sclk !== last_s) u++;
         last = ph1;
         last_s = sclk;
      end
   endtask : count_ph
   task automatic sleep(input logic [7:0] kv, input cpb_pm_t exp);
      @(posedge core_clk_in);
      sleep_instr <= 1'b1;
      key <= kv;
      @(posedge core_clk_in);
      sleep_instr <= 1'b0;
      @(posedge core_clk_in);
      #1;
      chk({14'h0, pm}, {14'h0, exp});
   endtask : sleep
   task automatic wake(input logic e, input cpb_pm_t exp);
      @(posedge core_clk_in);
      int_p <= ~e;
      ext_p <= e;
      repeat (2) @(posedge core_clk_in);
      int_p <= 1'b0;
      ext_p <= 1'b0;
      #1;
      chk({14'h0, pm}, {14'h0, exp});
   endtask : wake
   // ----------------------------------------
   // boot results against the noted values
   // ----------------------------------------
   always @(posedge done) begin
      #1;
      if (exp_q.size() == 0) chk(16'h0, 16'h1);
      else chk({cfg0, b1}, exp_q.pop_front());
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [15:0] t;
      logic [15:0] u;
      reset_n_in <= 1'b0;
      for (k = 0; k < 4; k++) begin
         rnd = xs(rnd);
         boot(2'h3, 8'hC0 | (k[7:0] << 4) | {4'h0, rnd[3:0]}, (k == 2) ? 8'd40 : 8'd0);
         t = (k == 2) ? 16'd40 : 16'(10 * k);
         chk({15'h0, len >= t && len <= t + 8}, 16'h1);
      end
      for (k = 0; k < 4; k++) begin
         boot(k[1:0], 8'hC1, 8'h00);
         count_ph(t, u);
         chk(t, (k == 3) ? 16'd32 : (k == 1) ? 16'd16 : 16'd8);
         chk(u, (k == 3) ? 16'd32 : (k == 1) ? 16'd16 : 16'd8);
      end
      boot(2'h3, 8'hC1, 8'h00);
      sleep(8'h01, CPB_PM_IDLE);
      wake(1'b0, CPB_PM_RUN);
      sleep(8'h03, CPB_PM_STBY);
      wake(1'b0, CPB_PM_STBY);
      wake(1'b1, CPB_PM_RUN);
      exp_q.push_back({8'hC1, data});
      sleep(8'h05, CPB_PM_RUN);
      repeat (3) @(posedge core_clk_in);
      wait_boot(len);
      sleep(8'h02, CPB_PM_PDOWN);
      chk({15'h0, osc}, 16'h0);
      boot(2'h3, 8'hC0, 8'h00);
      sleep(8'h02, CPB_PM_RUN);
      sleep(8'h03, CPB_PM_RUN);
      chk({15'h0, cpu_en}, 16'h1);
      repeat (4) @(posedge core_clk_in);
      stop_test();
   end
endmodule : testbench
